// ---- sfte_engine.sv ----
// SPI frame timing engine: four-wire SPI in all clock modes, master or slave.
// Assumes an APB master on pclk and pin levels that arrive asynchronously.
//
// Notes on behaviour
// [RULE_01] Words 4 to 16 bits, MSB first.
// [RULE_02] Polarity picks serial clock rest level.
// [RULE_03] Phase picks first or second capture edge.
// [RULE_04] Polarity cleared: clock idles low.
// [RULE_05] Polarity set: clock idles high.
// [RULE_06] Idle: select high, data out low.
// [RULE_07] Master drives clock; slave only listens.
// [RULE_08] Master starts frame when enabled with data.
// [RULE_09] Phase cleared: slave shows first bit immediately.
// [RULE_10] Phase cleared: bit after half, edge after more.
// [RULE_11] Mode 0: capture rising, change falling.
// [RULE_12] Mode 2: first edge falls, capture falling.
// [RULE_13] Mode 1: first bit with rising edge.
// [RULE_14] Mode 1: capture falling, change rising.
// [RULE_15] Mode 3: first bit with falling edge.
// [RULE_16] Mode 3: capture rising, change falling.
// [RULE_17] Select rises one period after last capture.
// [RULE_18] Phase cleared: select pulses between words.
// [RULE_19] Phase cleared: slave reloads only when deselected.
// [RULE_20] Phase set: select stays low across burst.
// [RULE_21] Burst ends one period after last capture.
// [RULE_22] Finished word pushed out, next word loaded.
`timescale 1ns/1ns
module sfte_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  input wire logic frame_select_line_in,
  output logic frame_select_line_out,
  output logic frame_select_line_oe,
  output logic serial_out_line,
  output logic serial_out_line_oe,
  input wire logic serial_in_line
);

  typedef struct packed {
    sfte_pkg::sfte_state_t st;
    logic [15:0] ctrl;
    logic [15:0] tx_hold;
    logic tx_full;
    logic [15:0] rx_hold;
    logic rx_valid;
    logic overrun;
    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    logic [4:0] bits;
    logic [5:0] edges;
    logic [1:0] tail;
    logic sclk;
    logic sclk_prev;
    logic fss;
    logic dout;
    logic [31:0] rdata;
  } sfte_regs_t;

  localparam sfte_regs_t REGS_RESET = '{
    st: sfte_pkg::ST_IDLE,
    ctrl: sfte_pkg::CTRL_RESET,
    tx_hold: 16'h0000,
    tx_full: 1'h0,
    rx_hold: 16'h0000,
    rx_valid: 1'h0,
    overrun: 1'h0,
    tx_shift: 16'h0000,
    rx_shift: 16'h0000,
    bits: 5'h00,
    edges: 6'h00,
    tail: 2'h0,
    sclk: 1'h0,
    sclk_prev: 1'h0,
    fss: 1'h1,
    dout: 1'h0,
    rdata: 32'h0000_0000
  };

  sfte_regs_t r;
  sfte_regs_t next_r;

  logic [2:0] pins_sync;
  logic s_sclk;
  logic s_fss;
  logic s_din;
  logic tick;
  logic run;

  logic en;
  logic master;
  logic slave;
  logic cpol;
  logic cpha;
  logic [3:0] size_code;
  logic [4:0] nbits;
  logic [5:0] last_edge;
  logic [3:0] status;
  logic [31:0] read_mux;
  logic mapped;
  logic apb_wr;
  logic apb_rd;

  logic start;
  logic edge_ev;
  logic leading;
  logic cap;
  logic chg;
  logic done;
  logic final_edge;

  // Pins cross into pclk first; select goes in inverted so reset reads deselected.
  sfte_sync2 #(
    .W(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({serial_clock_line_in, !frame_select_line_in, serial_in_line}),
    .sync_out(pins_sync)
  );

  assign s_sclk = pins_sync[2];
  assign s_fss = !pins_sync[1];
  assign s_din = pins_sync[0];

  // The divider only runs while the master has work to do.
  assign run = master && (r.st != sfte_pkg::ST_IDLE || r.tx_full);

  sfte_rate_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .half_div(r.ctrl[sfte_pkg::CTRL_DIV_MSB:sfte_pkg::CTRL_DIV_LSB]),
    .tick(tick)
  );

  // Configuration decode.
  always_comb begin
    en = r.ctrl[sfte_pkg::CTRL_EN];
    master = en && !r.ctrl[sfte_pkg::CTRL_SLAVE];
    slave = en && r.ctrl[sfte_pkg::CTRL_SLAVE];
    // [RULE_02] rest level choice
    cpol = r.ctrl[sfte_pkg::CTRL_CPOL];
    // [RULE_03] capture edge choice
    cpha = r.ctrl[sfte_pkg::CTRL_CPHA];
    // [RULE_01] word size clamp
    size_code = r.ctrl[sfte_pkg::CTRL_SIZE_MSB:sfte_pkg::CTRL_SIZE_LSB];
    if (size_code < sfte_pkg::SIZE_CODE_MIN) begin
      size_code = sfte_pkg::SIZE_CODE_MIN;
    end
    nbits = {1'h0, size_code} + 5'h01;
    last_edge = {nbits, 1'h0};
  end

  // Register read side and decode.
  always_comb begin
    status = '0;
    status[sfte_pkg::ST_BUSY] = (r.st != sfte_pkg::ST_IDLE);
    status[sfte_pkg::ST_TXFULL] = r.tx_full;
    status[sfte_pkg::ST_RXVALID] = r.rx_valid;
    status[sfte_pkg::ST_OVERRUN] = r.overrun;
    mapped = 1'h1;
    unique case (paddr)
      sfte_pkg::ADDR_CTRL: read_mux = {16'h0000, r.ctrl};
      sfte_pkg::ADDR_STATUS: read_mux = {28'h000_0000, status};
      sfte_pkg::ADDR_TXDATA: read_mux = {16'h0000, r.tx_hold};
      sfte_pkg::ADDR_RXDATA: read_mux = {16'h0000, r.rx_hold};
      default: begin
        read_mux = 32'h0000_0000;
        mapped = 1'h0;
      end
    endcase
    apb_wr = psel && penable && pwrite && mapped;
    apb_rd = psel && penable && !pwrite && mapped;
  end

  // The slave answers every access in its first access cycle.
  assign pready = 1'h1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = r.rdata;

  always_comb begin
    next_r = r;
    start = 1'h0;
    edge_ev = 1'h0;
    cap = 1'h0;
    chg = 1'h0;
    done = 1'h0;
    final_edge = 1'h0;
    next_r.sclk_prev = s_sclk;

    // Read data are captured in the setup cycle and held through access.
    if (psel && !penable) begin
      next_r.rdata = read_mux;
    end
    if (apb_wr && paddr == sfte_pkg::ADDR_CTRL) begin
      next_r.ctrl = pwdata[sfte_pkg::CTRL_W-1:0];
    end
    // A write while the holding word is still waiting is dropped.
    if (apb_wr && paddr == sfte_pkg::ADDR_TXDATA && !r.tx_full) begin
      next_r.tx_hold = pwdata[sfte_pkg::WORD_W-1:0];
      next_r.tx_full = 1'h1;
    end
    if (apb_rd && paddr == sfte_pkg::ADDR_RXDATA) begin
      next_r.rx_valid = 1'h0;
      next_r.overrun = 1'h0;
    end

    // Master leading edge is judged on the driven level, slave on the pin.
    leading = ((master ? r.sclk : r.sclk_prev) == cpol);

    unique case (r.st)
      sfte_pkg::ST_IDLE: begin
        // [RULE_04] [RULE_05] clock at rest
        next_r.sclk = cpol;
        // [RULE_06] idle line levels
        next_r.fss = 1'h1;
        next_r.dout = 1'h0;
        if (master && tick && r.tx_full) begin
          // [RULE_08] master frame start
          start = 1'h1;
          next_r.fss = 1'h0;
          next_r.st = sfte_pkg::ST_LEAD;
        end else if (slave && !s_fss) begin
          // [RULE_09] slave shows MSB at once
          start = 1'h1;
          chg = !cpha;
          next_r.st = sfte_pkg::ST_SHIFT;
        end
      end
      sfte_pkg::ST_LEAD: begin
        if (tick) begin
          // [RULE_10] first bit after half period
          chg = 1'h1;
          next_r.st = sfte_pkg::ST_SHIFT;
          next_r.edges = 6'h00;
          if (cpha) begin
            // [RULE_13] [RULE_15] first edge with first bit
            next_r.sclk = !r.sclk;
            next_r.edges = 6'h01;
          end
        end
      end
      sfte_pkg::ST_SHIFT: begin
        if (master) begin
          if (tick) begin
            edge_ev = 1'h1;
            next_r.sclk = !r.sclk;
            next_r.edges = r.edges + 6'h01;
            final_edge = (next_r.edges == last_edge);
          end
        end else if (s_fss) begin
          // [RULE_19] deselect ends the slave word
          next_r.st = sfte_pkg::ST_IDLE;
          next_r.dout = 1'h0;
        end else if (s_sclk != r.sclk_prev) begin
          edge_ev = 1'h1;
        end
      end
      sfte_pkg::ST_TAIL: begin
        if (tick) begin
          if (r.tail == 2'h1) begin
            // [RULE_17] [RULE_21] select released
            next_r.fss = 1'h1;
            next_r.dout = 1'h0;
            next_r.st = sfte_pkg::ST_IDLE;
          end else begin
            next_r.tail = r.tail - 2'h1;
          end
        end
      end
      default: begin
        next_r.st = sfte_pkg::ST_IDLE;
      end
    endcase

    // [RULE_11] [RULE_12] [RULE_14] [RULE_16] edge roles
    if (edge_ev) begin
      if (leading ^ cpha) begin
        cap = 1'h1;
      end else if (!final_edge) begin
        chg = 1'h1;
      end
    end

    if (start) begin
      next_r.tx_shift = r.tx_full ? r.tx_hold : 16'h0000;
      next_r.tx_full = next_r.tx_full && !r.tx_full;
      next_r.rx_shift = 16'h0000;
      next_r.bits = 5'h00;
      next_r.edges = 6'h00;
    end

    // [RULE_01] MSB first on both lines
    if (cap) begin
      next_r.rx_shift = {r.rx_shift[sfte_pkg::WORD_W-2:0], s_din};
      next_r.bits = r.bits + 5'h01;
      done = (r.bits == {1'h0, size_code});
    end

    if (done) begin
      // [RULE_22] received word pushed
      next_r.rx_hold = next_r.rx_shift;
      if (next_r.rx_valid) begin
        next_r.overrun = 1'h1;
      end
      next_r.rx_valid = 1'h1;
      next_r.bits = 5'h00;
      // [RULE_20] phase set keeps select low
      if (cpha && (slave || (master && r.tx_full))) begin
        // [RULE_22] next word loaded
        next_r.tx_shift = r.tx_full ? r.tx_hold : 16'h0000;
        next_r.tx_full = next_r.tx_full && !r.tx_full;
        next_r.rx_shift = 16'h0000;
      end
    end

    if (final_edge) begin
      if (cpha && r.tx_full) begin
        next_r.st = sfte_pkg::ST_LEAD;
      end else begin
        // [RULE_18] phase cleared returns through idle
        next_r.st = sfte_pkg::ST_TAIL;
        next_r.tail = cpha ? sfte_pkg::TAIL_CPHA1 : sfte_pkg::TAIL_CPHA0;
      end
    end

    if (chg) begin
      next_r.dout = next_r.tx_shift[size_code];
      next_r.tx_shift = {next_r.tx_shift[sfte_pkg::WORD_W-2:0], 1'h0};
    end

    // Disabling the port abandons any frame in flight.
    if (!en) begin
      next_r.st = sfte_pkg::ST_IDLE;
      next_r.fss = 1'h1;
      next_r.dout = 1'h0;
      next_r.sclk = cpol;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign serial_clock_line_out = r.sclk;
  // [RULE_07] clock driver only as master
  assign serial_clock_line_oe = master;
  assign frame_select_line_out = r.fss;
  assign frame_select_line_oe = master;
  // [RULE_06] [RULE_08] data driver only inside a frame
  assign serial_out_line = r.dout;
  assign serial_out_line_oe = (r.st != sfte_pkg::ST_IDLE);

endmodule

// ---- sfte_pkg.sv ----
// Shared constants and types for the SPI frame timing engine.
// Assumes a 32-bit APB register bus and a single system clock.
package sfte_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned STATUS_W = 4;
  localparam int unsigned ADDR_W = 12;

  // Register byte offsets.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_TXDATA = 12'h008;
  localparam logic [11:0] ADDR_RXDATA = 12'h00c;

  // Control register fields.
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_SLAVE = 1;
  localparam int unsigned CTRL_CPOL = 2;
  localparam int unsigned CTRL_CPHA = 3;
  localparam int unsigned CTRL_SIZE_LSB = 4;
  localparam int unsigned CTRL_SIZE_MSB = 7;
  localparam int unsigned CTRL_DIV_LSB = 8;
  localparam int unsigned CTRL_DIV_MSB = 15;
  localparam logic [15:0] CTRL_RESET = 16'h0070;

  // Word size code is bits minus one; codes below this mean 4 bits.
  localparam logic [3:0] SIZE_CODE_MIN = 4'h3;

  // Status register fields.
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_TXFULL = 1;
  localparam int unsigned ST_RXVALID = 2;
  localparam int unsigned ST_OVERRUN = 3;

  // Half serial periods from the final serial clock edge to frame select release.
  localparam logic [1:0] TAIL_CPHA0 = 2'h1;
  localparam logic [1:0] TAIL_CPHA1 = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LEAD  = 4'h2,
    ST_SHIFT = 4'h4,
    ST_TAIL  = 4'h8
  } sfte_state_t;

endpackage

// ---- sfte_rate_div.sv ----
// Divider that gives one-cycle pulses, one per half serial clock period.
// Assumes run is a level from logic on pclk; counting restarts when it drops.
`timescale 1ns/1ns
module sfte_rate_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] half_div,
  output logic tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } sfte_div_t;

  sfte_div_t r;
  sfte_div_t next_r;

  // A half period lasts half_div plus one pclk cycles.
  always_comb begin
    next_r = r;
    next_r.tick = 1'h0;
    if (!run) begin
      next_r.cnt = 8'h00;
    end else if (r.cnt == half_div) begin
      next_r.cnt = 8'h00;
      next_r.tick = 1'h1;
    end else begin
      next_r.cnt = r.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule

// ---- sfte_spi_slave.sv ----
// Behavioural off-chip SPI slave that answers the engine in master role.
// Assumes the bench sets clock mode, word length and the word to return.
`timescale 1ns/1ns
module sfte_spi_slave (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [4:0] nbits,
  input wire logic [15:0] tx_word,
  output logic miso,
  output logic [15:0] rx_word
);
  logic [15:0] sh;
  logic [4:0] cnt;
  initial begin
    miso = 1'b0;
    rx_word = 16'h0;
    sh = 16'h0;
    cnt = 5'h0;
  end
  always @(negedge sel_n) begin
    sh = tx_word << (5'h10 - nbits);
    cnt = 5'h0;
    if (!cpha) begin
      miso = sh[15];
      sh = sh << 1;
    end
  end
  // A released line must not keep showing the last bit.
  always @(posedge sel_n) miso = ~miso;
  always @(sclk) begin
    if (sel_n === 1'b0) begin
      if ((sclk != cpol) ^ cpha) begin
        rx_word = {rx_word[14:0], mosi};
        cnt = cnt + 5'h1;
        if (cpha && cnt == nbits) begin
          sh = tx_word << (5'h10 - nbits);
          cnt = 5'h0;
        end
      end else begin
        miso = sh[15];
        sh = sh << 1;
      end
    end
  end
endmodule

// ---- sfte_sva.sv ----
// Checker for the SPI frame timing engine, watching its top-level ports.
// Assumes the control register is written only over APB at its own address.
`timescale 1ns/1ns
module sfte_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic serial_clock_line_out,
  input wire logic serial_clock_line_oe,
  input wire logic frame_select_line_out,
  input wire logic frame_select_line_oe,
  input wire logic serial_out_line,
  input wire logic serial_out_line_oe
);
  logic [15:0] ctl;
  logic sclk_q;
  logic chg;
  logic [9:0] cnt;
  logic [9:0] since;
  logic [6:0] ecnt;
  logic [8:0] h;
  logic [4:0] n;
  assign h = {1'b0, ctl[15:8]} + 9'h1;
  assign n = (ctl[7:4] < 4'h3) ? 5'h4 : {1'b0, ctl[7:4]} + 5'h1;
  assign chg = serial_clock_line_out != sclk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= sfte_pkg::CTRL_RESET;
      sclk_q <= 1'b0;
      cnt <= 10'h0;
      since <= 10'h0;
      ecnt <= 7'h0;
    end else begin
      if (psel && penable && pwrite && paddr == sfte_pkg::ADDR_CTRL) begin
        ctl <= pwdata[15:0];
      end
      sclk_q <= serial_clock_line_out;
      cnt <= frame_select_line_out ? 10'h0 : cnt + 10'h1;
      since <= chg ? 10'h1 : since + 10'h1;
      ecnt <= frame_select_line_out ? 7'h0 : ecnt + {6'h0, chg};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence frame_start;
    $fell(frame_select_line_out);
  endsequence
  sequence first_edge;
    !frame_select_line_out && chg && ecnt == 7'h0;
  endsequence
  bad_addr_a: assert property (
    psel && penable && paddr > sfte_pkg::ADDR_RXDATA |-> pslverr)
    else $error("unmapped access not flagged");
  clk_idle_a: assert property (
    frame_select_line_out && ctl == $past(ctl, 2) |-> serial_clock_line_out == ctl[2])
    else $error("serial clock not at rest level");
  dout_idle_a: assert property (
    frame_select_line_out && !ctl[1] |-> !serial_out_line)
    else $error("data out not low while idle");
  clk_oe_a: assert property (
    serial_clock_line_oe == (ctl[0] && !ctl[1]))
    else $error("clock driver enable wrong");
  fss_oe_a: assert property (
    frame_select_line_oe == (ctl[0] && !ctl[1]))
    else $error("select driver enable wrong");
  start_a: assert property (
    frame_start |-> serial_out_line_oe && ctl[0] && !ctl[1])
    else $error("frame started without enable");
  first_edge_a: assert property (
    first_edge |-> serial_clock_line_out != ctl[2] && cnt == (ctl[3] ? {1'b0, h} : {h, 1'b0}))
    else $error("first clock edge misplaced");
  end_sel_a: assert property (
    $rose(frame_select_line_out) && ctl[0] |-> since == (ctl[3] ? {h, 1'b0} : {1'b0, h}))
    else $error("select released at wrong time");
  edge_count_a: assert property (
    $rose(frame_select_line_out) && ctl[0] && !ctl[3] |-> ecnt == {1'b0, n, 1'b0})
    else $error("wrong edge count in word");
endmodule

bind sfte_engine sfte_sva sfte_sva_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pslverr, .serial_clock_line_out, .serial_clock_line_oe, .frame_select_line_out,
  .frame_select_line_oe, .serial_out_line, .serial_out_line_oe);

// ---- sfte_sync2.sv ----
// Two flip-flop synchroniser for a group of independent pin levels.
// Assumes each bit is an unrelated level from outside the pclk domain.
`timescale 1ns/1ns
module sfte_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sfte_sync_t;

  sfte_sync_t r;
  sfte_sync_t next_r;

  // The first stage feeds only the second stage.
  always_comb begin
    next_r.meta = async_in;
    next_r.sync = r.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.sync;

endmodule

// ---- sfte_tb.sv ----
// Self-checking bench: APB master plus an SPI slave model in all four modes.
// Assumes the engine answers APB with pready; covers master and slave roles.
`timescale 1ns/1ns
module tb;
  localparam logic [15:0] SW = 16'h9c6b;
  localparam logic [15:0] TW = 16'ha7d4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic serial_clock_line_out, serial_clock_line_oe, frame_select_line_out;
  logic frame_select_line_oe, serial_out_line, serial_out_line_oe, miso;
  logic cpol, cpha;
  logic m_sclk, m_fss, m_dat, slv;
  logic [7:0] mrx;
  logic [3:0] code;
  logic [4:0] nbits;
  logic [15:0] mask, srx;
  logic [3:0] codes [4] = '{4'h2, 4'h7, 4'hf, 4'hb};
  int compares, n_mismatch, nrise;
  sfte_engine sfte_engine_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .serial_clock_line_in(m_sclk), .serial_clock_line_out,
    .serial_clock_line_oe, .frame_select_line_in(m_fss), .frame_select_line_out,
    .frame_select_line_oe, .serial_out_line, .serial_out_line_oe,
    .serial_in_line(slv ? m_dat : miso));
  sfte_spi_slave sfte_spi_slave_i (.sclk(serial_clock_line_out), .sel_n(frame_select_line_out),
    .mosi(serial_out_line), .cpol, .cpha, .nbits, .tx_word(SW), .miso, .rx_word(srx));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge frame_select_line_out) nrise++;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Far-side master for the slave role: mode 0, MSB first, 320 ns serial period.
  task automatic spim(input logic [7:0] w);
    m_fss <= 1'b0;
    m_dat <= w[7];
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge pclk);
      m_sclk <= 1'b1;
      mrx = {mrx[6:0], serial_out_line};
      repeat (4) @(posedge pclk);
      m_sclk <= 1'b0;
      if (i > 0) m_dat <= w[i-1];
    end
    repeat (4) @(posedge pclk);
    m_fss <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic wait_clr(input logic [3:0] bits);
    do apb(1'b0, sfte_pkg::ADDR_STATUS, 32'h0); while ((q[3:0] & bits) !== 4'h0);
  endtask
  task automatic end_sim;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    cpol = 1'b0;
    cpha = 1'b0;
    nbits = 5'h8;
    m_sclk = 1'b0;
    m_fss = 1'b1;
    m_dat = 1'b0;
    slv = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sfte_pkg::ADDR_CTRL, 32'h0);
    chk(q, {16'h0, sfte_pkg::CTRL_RESET});
    apb(1'b0, 12'h010, 32'h0);
    chk({serr, q[30:0]}, 32'h80000000);
    for (int m = 0; m < 4; m++) begin
      cpol = m[0];
      cpha = m[1];
      code = codes[m];
      nbits = (code < 4'h3) ? 5'h4 : {1'b0, code} + 5'h1;
      mask = 16'hffff >> (5'h10 - nbits);
      apb(1'b1, sfte_pkg::ADDR_CTRL, {16'h0, 8'h03, code, cpha, cpol, 2'b01});
      nrise = 0;
      apb(1'b1, sfte_pkg::ADDR_TXDATA, 32'h35e1);
      wait_clr(4'h2);
      apb(1'b1, sfte_pkg::ADDR_TXDATA, {16'h0, TW});
      wait_clr(4'h3);
      chk(q, 32'hc);
      apb(1'b0, sfte_pkg::ADDR_RXDATA, 32'h0);
      chk(q, {16'h0, SW & mask});
      chk({16'h0, srx & mask}, {16'h0, TW & mask});
      chk(nrise, cpha ? 32'h1 : 32'h2);
      chk({29'h0, serial_clock_line_out, frame_select_line_out, serial_out_line},
        {29'h0, cpol, 2'b10});
    end
    // Slave role, mode 0, 8-bit words, clocked by the far-side master task.
    slv = 1'b1;
    apb(1'b1, sfte_pkg::ADDR_CTRL, 32'h0000_0073);
    apb(1'b1, sfte_pkg::ADDR_TXDATA, {16'h0, TW});
    spim(SW[7:0]);
    chk({24'h0, mrx}, {24'h0, TW[7:0]});
    chk({30'h0, serial_clock_line_oe, frame_select_line_oe}, 32'h0);
    apb(1'b0, sfte_pkg::ADDR_RXDATA, 32'h0);
    chk(q, {24'h0, SW[7:0]});
    apb(1'b1, sfte_pkg::ADDR_TXDATA, {16'h0, SW});
    spim(TW[7:0]);
    chk({24'h0, mrx}, {24'h0, SW[7:0]});
    apb(1'b0, sfte_pkg::ADDR_RXDATA, 32'h0);
    chk(q, {24'h0, TW[7:0]});
    end_sim;
  end
endmodule
